//--- hw/pte_tx_link.sv
// transmit coder, scrambler, symbol mapper and link monitor
`timescale 1ns/1ps
module pte_tx_link
	import pte_pkg::*;
#(
	parameter int STAB_CYC = 20000,
	parameter int MAXW_CYC = 20000
) (
	input  wire logic         i_clk,
	input  wire logic         i_rstn,
	input  wire logic         i_role_master,
	input  wire logic         i_loc_rcvr_ok,
	input  wire pte_tx_mode_t i_tx_mode,
	input  wire logic         i_tx_en,
	input  wire logic [3:0]   i_txd,
	output logic              o_mii_ready,
	input  wire logic         i_sym_ready,
	output logic [1:0]        o_ta,
	output logic [1:0]        o_tb,
	output logic              o_link_ok
);
	// ************************************************************
	// symbol tables
	// ************************************************************
	function automatic logic [3:0] map_data(input logic [2:0] sd);
		case (sd)
			3'h0:    map_data = {PTE_T_NEG, PTE_T_NEG};
			3'h1:    map_data = {PTE_T_NEG, PTE_T_ZERO};
			3'h2:    map_data = {PTE_T_NEG, PTE_T_POS};
			3'h3:    map_data = {PTE_T_ZERO, PTE_T_NEG};
			3'h4:    map_data = {PTE_T_ZERO, PTE_T_POS};
			3'h5:    map_data = {PTE_T_POS, PTE_T_NEG};
			3'h6:    map_data = {PTE_T_POS, PTE_T_ZERO};
			default: map_data = {PTE_T_POS, PTE_T_POS};
		endcase
	endfunction

	function automatic logic [3:0] map_idle(input logic [2:0] sd);
		case (sd)
			3'h0:    map_idle = {PTE_T_ZERO, PTE_T_NEG};
			3'h1:    map_idle = {PTE_T_NEG, PTE_T_POS};
			3'h2:    map_idle = {PTE_T_POS, PTE_T_NEG};
			3'h3:    map_idle = {PTE_T_NEG, PTE_T_NEG};
			3'h4:    map_idle = {PTE_T_POS, PTE_T_POS};
			3'h5:    map_idle = {PTE_T_ZERO, PTE_T_POS};
			3'h6:    map_idle = {PTE_T_NEG, PTE_T_ZERO};
			default: map_idle = {PTE_T_POS, PTE_T_ZERO};
		endcase
	endfunction

	function automatic logic [3:0] map_train(input logic [2:0] sd);
		map_train = {(sd[0] ? PTE_T_POS : PTE_T_NEG), (sd[1] ? PTE_T_POS : PTE_T_NEG)};
	endfunction

	// ************************************************************
	// input buffer and 4b/3b regrouping
	// ************************************************************
	logic       fifo_valid;
	logic [3:0] fifo_data;
	logic       load;
	logic [6:0] bit_buf;
	logic [2:0] bit_cnt;
	logic       take;
	logic [2:0] cnt_a;
	logic [6:0] buf_a;
	logic       send_data;

	pte_fifo #(
		.WIDTH (PTE_NIB_W),
		.DEPTH (PTE_FIFO_DEPTH)
	) u_fifo (
		.i_clk      (i_clk),
		.i_rstn     (i_rstn),
		.i_wr_valid (i_tx_en),
		.o_wr_ready (o_mii_ready),
		.i_wr_data  (i_txd),
		.o_rd_valid (fifo_valid),
		.i_rd_ready (load),
		.o_rd_data  (fifo_data)
	);

	assign send_data = (i_tx_mode == PTE_SEND_N) && i_tx_en;
	assign take      = i_sym_ready && send_data && (bit_cnt >= PTE_GRP_BITS);
	assign cnt_a     = take ? 3'(bit_cnt - PTE_GRP_BITS) : bit_cnt;
	assign buf_a     = take ? (bit_buf >> PTE_GRP_BITS) : bit_buf;
	assign load      = i_tx_en && fifo_valid && (cnt_a <= PTE_LOAD_ROOM);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bit_buf <= '0;
			bit_cnt <= '0;
		end else if (!i_tx_en) begin
			bit_buf <= '0;
			bit_cnt <= '0;
		end else if (load) begin
			bit_buf <= buf_a | (7'(fifo_data) << cnt_a);
			bit_cnt <= 3'(cnt_a + 3'h4);
		end else begin
			bit_buf <= buf_a;
			bit_cnt <= cnt_a;
		end
	end

	// ************************************************************
	// side-stream scrambler
	// ************************************************************
	logic [PTE_SCR_W-1:0] scr;
	logic [PTE_SCR_W-1:0] taps;
	logic [2:0]           sy;
	logic [2:0]           grp;
	logic [2:0]           sd;
	logic [2:0]           sd_q;

	assign taps = i_role_master ? PTE_TAPS_MASTER : PTE_TAPS_SLAVE;
	assign sy   = {scr[PTE_SY2_POS], scr[PTE_SY1_POS], scr[PTE_SY0_POS]};
	assign grp  = send_data ? bit_buf[2:0] : 3'h0;
	// idle streams get one more whitening bit so their pattern differs from data
	assign sd   = (grp ^ sy) ^ {(!send_data && scr[PTE_IDLE_POS]), 2'h0};

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			scr <= PTE_SCR_SEED;
		end else if (i_sym_ready) begin
			scr <= {scr[PTE_SCR_W-2:0], ^(scr & taps)};
		end
	end

	// ************************************************************
	// ternary pair generation
	// ************************************************************
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sd_q <= '0;
			o_ta <= PTE_T_ZERO;
			o_tb <= PTE_T_ZERO;
		end else if (i_sym_ready) begin
			sd_q <= sd;
			case (i_tx_mode)
				PTE_SEND_I: begin
					{o_ta, o_tb} <= map_train(sd);
				end
				PTE_SEND_N: begin
					if (i_tx_en) begin
						{o_ta, o_tb} <= map_data(sd);
					end else begin
						{o_ta, o_tb} <= map_idle(sd);
					end
				end
				default: begin
					{o_ta, o_tb} <= {PTE_T_ZERO, PTE_T_ZERO};
				end
			endcase
		end
	end

	// ************************************************************
	// link monitor
	// ************************************************************
	localparam logic [PTE_TMR_W-1:0] STAB_LAST = PTE_TMR_W'(STAB_CYC - 1);
	localparam logic [PTE_TMR_W-1:0] MAXW_LAST = PTE_TMR_W'(MAXW_CYC - 1);

	pte_lm_state_t        lm_state;
	logic [PTE_TMR_W-1:0] tmr;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lm_state <= PTE_LM_FAIL;
			tmr      <= '0;
		end else begin
			case (lm_state)
				PTE_LM_FAIL: begin
					tmr <= '0;
					if (i_loc_rcvr_ok) begin
						lm_state <= PTE_LM_WAIT;
					end
				end
				PTE_LM_WAIT: begin
					if (!i_loc_rcvr_ok) begin
						lm_state <= PTE_LM_FAIL;
					end else if (tmr == STAB_LAST) begin
						lm_state <= PTE_LM_UP;
					end else begin
						tmr <= tmr + 1'b1;
					end
				end
				PTE_LM_UP: begin
					tmr <= '0;
					if (!i_loc_rcvr_ok) begin
						lm_state <= PTE_LM_HOLD;
					end
				end
				PTE_LM_HOLD: begin
					if (i_loc_rcvr_ok) begin
						lm_state <= PTE_LM_UP;
					end else if (tmr == MAXW_LAST) begin
						lm_state <= PTE_LM_FAIL;
					end else begin
						tmr <= tmr + 1'b1;
					end
				end
				default: begin
					lm_state <= PTE_LM_FAIL;
				end
			endcase
		end
	end

	assign o_link_ok = (lm_state == PTE_LM_UP) || (lm_state == PTE_LM_HOLD);

	// ************************************************************
	// checks
	// ************************************************************
	int unsigned ok_run;
	int unsigned lost_run;
	localparam int unsigned STAB_MIN = STAB_CYC;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ok_run   <= 0;
			lost_run <= 0;
		end else begin
			ok_run   <= i_loc_rcvr_ok ? ok_run + 1 : 0;
			lost_run <= (o_link_ok && !i_loc_rcvr_ok) ? lost_run + 1 : 0;
		end
	end

	sequence s_link_lost;
		o_link_ok && !i_loc_rcvr_ok;
	endsequence

	// hold is entered on the first lost edge and counts maxwait edges more before failing
	sequence s_wait_over;
		lost_run == MAXW_CYC;
	endsequence

	a_link_up_gate: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$rose(o_link_ok) |-> $past(lm_state) == PTE_LM_WAIT)
		else $error("link reported up without passing through wait");

	a_stab_held: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$rose(o_link_ok) |-> ok_run >= STAB_MIN)
		else $error("link up before receiver held ok long enough");

	a_maxwait_fail: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(s_link_lost and s_wait_over) |=> !o_link_ok)
		else $error("link not dropped after maxwait");

	a_hold_keeps_up: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(s_link_lost and (lost_run < MAXW_CYC)) |=> o_link_ok)
		else $error("link dropped before maxwait expired");

	a_role_taps: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_sym_ready && i_role_master |=> scr[0] == ^($past(scr) & PTE_TAPS_MASTER))
		else $error("master scrambler feedback wrong");

	a_scr_alive: assert property (@(posedge i_clk) disable iff (!i_rstn)
		scr != '0)
		else $error("scrambler locked at zero");

	a_train_map: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_sym_ready && i_tx_mode == PTE_SEND_I |=> o_ta != PTE_T_ZERO && o_tb != PTE_T_ZERO)
		else $error("training symbol has a zero level");

	a_data_map: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_sym_ready && send_data |=> {o_ta, o_tb} != {PTE_T_ZERO, PTE_T_ZERO})
		else $error("data symbol pair is zero zero");

	a_idle_map: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_sym_ready && i_tx_mode == PTE_SEND_N && !i_tx_en |=> {o_ta, o_tb} == map_idle(sd_q))
		else $error("normal idle symbol not from idle table");

	a_regroup_take: assert property (@(posedge i_clk) disable iff (!i_rstn)
		take && !load && i_tx_en |=> bit_cnt == $past(bit_cnt) - PTE_GRP_BITS)
		else $error("regrouper did not consume three bits");
endmodule

//--- include/pte_pkg.sv
// shared constants and types of the transmit coder and link monitor
package pte_pkg;
	// ************************************************************
	// transmit modes and link monitor states
	// ************************************************************
	typedef enum logic [1:0] {
		PTE_SEND_Z = 2'h0,
		PTE_SEND_I = 2'h1,
		PTE_SEND_N = 2'h3
	} pte_tx_mode_t;

	typedef enum logic [1:0] {
		PTE_LM_FAIL = 2'h0,
		PTE_LM_WAIT = 2'h1,
		PTE_LM_UP   = 2'h3,
		PTE_LM_HOLD = 2'h2
	} pte_lm_state_t;

	// ************************************************************
	// ternary symbol encoding, two bits signed
	// ************************************************************
	localparam logic [1:0] PTE_T_ZERO = 2'h0;
	localparam logic [1:0] PTE_T_POS  = 2'h1;
	localparam logic [1:0] PTE_T_NEG  = 2'h3;

	// ************************************************************
	// scrambler, regrouping, fifo depth and link timer width
	// ************************************************************
	localparam int          PTE_SCR_W       = 33;
	localparam logic [32:0] PTE_SCR_SEED    = 33'h0_0000_0001;
	localparam logic [32:0] PTE_TAPS_MASTER = 33'h1_0000_1000;
	localparam logic [32:0] PTE_TAPS_SLAVE  = 33'h1_0008_0000;
	localparam int          PTE_SY0_POS     = 0;
	localparam int          PTE_SY1_POS     = 3;
	localparam int          PTE_SY2_POS     = 8;
	localparam int          PTE_IDLE_POS    = 12;
	localparam int          PTE_GRP_W       = 3;
	localparam int          PTE_NIB_W       = 4;
	localparam logic [2:0]  PTE_GRP_BITS    = 3'h3;
	localparam logic [2:0]  PTE_LOAD_ROOM   = 3'h3;
	localparam int          PTE_FIFO_DEPTH  = 16;
	localparam int          PTE_TMR_W       = 24;
endpackage

//--- hw/pte_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module pte_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_rstn,
	input  wire logic             i_wr_valid,
	output logic                  o_wr_ready,
	input  wire logic [WIDTH-1:0] i_wr_data,
	output logic                  o_rd_valid,
	input  wire logic             i_rd_ready,
	output logic      [WIDTH-1:0] o_rd_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             full;
	logic             empty;

	assign empty      = (wr_ptr == rd_ptr);
	assign full       = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
	assign o_wr_ready = !full;
	assign o_rd_valid = !empty;
	assign o_rd_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge i_clk) begin
		if (i_wr_valid && !full) begin
			mem[wr_ptr[AW-1:0]] <= i_wr_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (i_wr_valid && !full) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (i_rd_ready && !empty) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	a_fifo_no_overrun: assert property (@(posedge i_clk) disable iff (!i_rstn)
		full |=> !empty)
		else $error("fifo lost its contents while full");
endmodule

//--- sim/pte_phy_partner.sv
// link partner model: symbol strobes, receiver status and symbol capture
`timescale 1ns/1ps
module pte_phy_partner
	import pte_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_run,
	input  wire logic [3:0] i_gap,
	input  wire logic       i_peer_on,
	input  wire logic [1:0] i_ta,
	input  wire logic [1:0] i_tb,
	output logic            o_sym_ready,
	output logic            o_rcvr_ok,
	output logic [3:0]      o_pair,
	output logic [15:0]     o_cnt
);
	logic [3:0] wait_cnt;
	logic       seen;

	// ****************************************************************
	// strobe pacing and capture of the pair that follows each strobe
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_sym_ready <= 1'b0;
			o_rcvr_ok   <= 1'b0;
			o_pair      <= 4'h0;
			o_cnt       <= 16'h0;
			wait_cnt    <= 4'h0;
			seen        <= 1'b0;
		end else begin
			// receiver status lags the peer by one cycle, as a real receiver would
			o_rcvr_ok <= i_peer_on;
			seen      <= o_sym_ready;
			if (seen) begin
				o_pair <= {i_ta, i_tb};
				o_cnt  <= o_cnt + 16'h1;
			end
			if (i_run && wait_cnt == 4'h0) begin
				o_sym_ready <= 1'b1;
				wait_cnt    <= i_gap;
			end else begin
				o_sym_ready <= 1'b0;
				if (wait_cnt != 4'h0) begin
					wait_cnt <= wait_cnt - 4'h1;
				end
			end
		end
	end
endmodule

//--- sim/pte_tx_link_tb_top.sv
// self-checking bench of the transmit coder and link monitor
`timescale 1ns/1ps
module pte_tx_link_tb_top;
	import pte_pkg::*;
	localparam int STAB = 4;
	localparam int MAXW = 6;
	logic         clk = 0, rstn = 0, role = 1, peer = 0, run = 0, tx_en = 0;
	logic [3:0]   txd = 4'h0, gap = 4'h0, pair;
	logic         sym_rdy, rcvr_ok, mii_rdy, link;
	logic [1:0]   ta, tb;
	logic [15:0]  cnt;
	logic [95:0]  seq [2];
	pte_tx_mode_t mode = PTE_SEND_Z;
	int           n_fail = 0, tests_run = 0;

	always #25 clk = ~clk;
	always @(posedge clk) if (tx_en) txd <= txd + 4'h1;

	pte_tx_link #(.STAB_CYC(STAB), .MAXW_CYC(MAXW)) i_dut (.i_clk(clk), .i_rstn(rstn),
		.i_role_master(role), .i_loc_rcvr_ok(rcvr_ok), .i_tx_mode(mode), .i_tx_en(tx_en),
		.i_txd(txd), .o_mii_ready(mii_rdy), .i_sym_ready(sym_rdy), .o_ta(ta), .o_tb(tb),
		.o_link_ok(link));
	pte_phy_partner i_peer (.i_clk(clk), .i_rstn(rstn), .i_run(run), .i_gap(gap),
		.i_peer_on(peer), .i_ta(ta), .i_tb(tb), .o_sym_ready(sym_rdy), .o_rcvr_ok(rcvr_ok),
		.o_pair(pair), .o_cnt(cnt));

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_sym(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic next_pair();
		logic [15:0] old;
		old = cnt;
		for (int i = 0; i < 40 && cnt == old; i++) tick(1);
		chk_bit(cnt != old, 1'b1);
	endtask
	task automatic do_reset(input logic r, input pte_tx_mode_t m, input logic go);
		@(posedge clk);
		rstn <= 1'b0;
		role <= r;
		mode <= m;
		run  <= go;
		peer <= 1'b0;
		tick(8);
		@(posedge clk);
		rstn <= 1'b1;
	endtask
	task automatic drive_peer(input logic v);
		@(posedge clk);
		peer <= v;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_symbols(input logic r, input int k);
		do_reset(r, PTE_SEND_I, 1'b1);
		for (int i = 0; i < 24; i++) begin
			next_pair();
			seq[k] = {seq[k][91:0], pair};
			chk_bit((pair[3:2] == PTE_T_POS || pair[3:2] == PTE_T_NEG) &&
				(pair[1:0] == PTE_T_POS || pair[1:0] == PTE_T_NEG), 1'b1);
		end
		@(posedge clk);
		mode  <= PTE_SEND_N;
		tx_en <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			next_pair();
			if (i > 1) chk_bit(pair != 4'h0 && pair[3:2] != 2'h2 && pair[1:0] != 2'h2, 1'b1);
		end
		@(posedge clk);
		tx_en <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			next_pair();
			if (i > 1) chk_bit(pair[3:2] != 2'h2 && pair[1:0] != 2'h2, 1'b1);
		end
		@(posedge clk);
		run <= 1'b0;
	endtask

	task automatic t_fifo();
		int   acc;
		logic refused;
		acc = 0;
		refused = 0;
		do_reset(1'b1, PTE_SEND_N, 1'b0);
		@(posedge clk);
		tx_en <= 1'b1;
		#1;
		for (int i = 0; i < 24; i++) begin
			if (mii_rdy) acc++;
			else refused = 1;
			tick(1);
		end
		// a full fifo plus the one nibble already loaded into the regroup buffer
		chk_bit(acc == PTE_FIFO_DEPTH + 1 && refused, 1'b1);
		@(posedge clk);
		gap <= 4'h2;
		run <= 1'b1;
		for (int i = 0; i < 30 && !mii_rdy; i++) tick(1);
		chk_bit(mii_rdy, 1'b1);
		@(posedge clk);
		tx_en <= 1'b0;
		run   <= 1'b0;
		gap   <= 4'h0;
	endtask

	task automatic t_link(input logic r);
		do_reset(r, PTE_SEND_I, 1'b0);
		drive_peer(1'b1);
		tick(1);
		drive_peer(1'b0);
		drive_peer(1'b1);
		tick(1 + STAB);
		chk_bit(link, 1'b0);
		tick(1);
		chk_bit(link, 1'b1);
		drive_peer(1'b0);
		tick(2);
		drive_peer(1'b1);
		tick(3);
		chk_bit(link, 1'b1);
		drive_peer(1'b0);
		tick(1 + MAXW);
		chk_bit(link, 1'b1);
		tick(1);
		chk_bit(link, 1'b0);
	endtask

	// ****************************************************************
	// main sequence and watchdog
	// ****************************************************************
	initial begin
		tick(2);
		chk_sym({ta, tb}, 4'h0);
		chk_bit(link, 1'b0);
		chk_bit(mii_rdy, 1'b1);
		tick(6);
		t_symbols(1'b1, 0);
		t_symbols(1'b0, 1);
		chk_bit(seq[0] !== seq[1], 1'b1);
		t_fifo();
		t_link(1'b1);
		t_link(1'b0);
		final_report();
	end
	initial begin
		tick(5000);
		n_fail++;
		final_report();
	end
endmodule
